// File: include/lbp_cfg.svh
// Constants for the OPERATING_MODE_BIT breathing PWM driver: register offsets, field
// positions, reset values, strobe codes and timing counts.
// Assumes a 250 MHz core clock and byte-wide register writes.
`ifndef LBP_CFG_SVH
`define LBP_CFG_SVH

// Register offsets
`define LBP_A_SHUTDOWN   8'h00
`define LBP_A_BREATH     8'h01
`define LBP_A_MODE       8'h02
`define LBP_A_CURRENT    8'h03
`define LBP_A_DUTY       8'h04
`define LBP_A_DUTY_UPD   8'h07
`define LBP_A_DELAY      8'h0a
`define LBP_A_RISEHOLD   8'h10
`define LBP_A_FALLOFF    8'h16
`define LBP_A_TIME_UPD   8'h1c
`define LBP_A_OUTCTL     8'h1d
`define LBP_A_RESET      8'h2f

// Reset values
`define LBP_RST_SHUTDOWN 8'h01
`define LBP_RST_OUTCTL   8'h01
`define LBP_RST_ZERO     8'h00

// Value that fires the update and reset strobes
`define LBP_STROBE_CODE  8'h00

// Field positions
`define LBP_SSD_BIT      0
`define LBP_EN_BIT       5
`define LBP_RAMP_BIT     5
`define LBP_HOLDSEL_BIT  4
`define LBP_MODE_BIT     5
`define LBP_OUTON_BIT    0
`define LBP_CS_HI        4
`define LBP_CS_LO        2
`define LBP_DUTY_HI      7
`define LBP_DUTY_LO      1
`define LBP_HI_NIB_HI    7
`define LBP_HI_NIB_LO    4
`define LBP_HI3_HI       7
`define LBP_HI3_LO       5
`define LBP_MID4_HI      4
`define LBP_MID4_LO      1

// Highest usable codes of the zero-able interval fields
`define LBP_DELAY_MAX    4'ha
`define LBP_HOLD_MAX     4'h8
`define LBP_OFF_MAX      4'ha

// Timing: shortest interval is 0.13 s, split into ramp steps
`define LBP_UNIT_NS      130000000
`define LBP_CLK_NS       4
`define LBP_RAMP_STEPS   128
`define LBP_STEP_CYCLES  ((`LBP_UNIT_NS) / ((`LBP_CLK_NS) * (`LBP_RAMP_STEPS)))

`endif

// File: include/lbp_pkg.sv
// Types shared by the OPERATING_MODE_BIT breathing PWM driver modules.
// Assumes nothing beyond the constants header.
`default_nettype none

package lbp_pkg;
    // Breathing sequencer phases
    typedef enum logic [2:0] {
        LBP_IDLE,
        LBP_DELAY,
        LBP_RISE,
        LBP_HOLD,
        LBP_FALL,
        LBP_OFF
    } lbp_state_t;
endpackage

`default_nettype wire

// File: include/lbp_tmr_if.sv
// Carrier between the breathing sequencer and its interval timer.
// Assumes both ends run on the same core clock.
`default_nettype none

interface lbp_tmr_if;
    logic       start;    // Restart interval, one-cycle pulse
    logic       tick;     // Ramp step enable
    logic       zero_len; // Interval of zero length
    logic [3:0] shift;    // Interval is 128 steps shifted left by this
    logic       done;     // Interval finished, one-cycle pulse
    logic [6:0] frac;     // Progress through interval, 0..127

    modport seq   (output start, output tick, output zero_len, output shift,
                   input done, input frac);
    modport timer (input start, input tick, input zero_len, input shift,
                   output done, output frac);
endinterface

`default_nettype wire

// File: core/lbp_interval_timer.sv
// Interval timer of the breathing sequencer: counts ramp steps through
// one interval and reports progress and completion.
// Assumes start and tick come from logic on the same clock.
`include "lbp_cfg.svh"
`default_nettype none

module lbp_interval_timer #(
    parameter int CNT_W = 17
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_b_i,
    // Sequencer side
    lbp_tmr_if.timer  tmr
);
    import lbp_pkg::*;

    // Refuse a counter too narrow for the longest interval
    initial
        if (CNT_W < 17)
            $error("lbp_interval_timer: CNT_W too small for longest interval");

    logic [CNT_W-1:0] cnt_reg;  // Steps elapsed in interval
    logic             run_reg;  // Interval in progress
    logic             done_reg; // Completion pulse
    logic [CNT_W-1:0] limit;    // Steps in this interval

    // Interval length doubles per code
    assign limit = CNT_W'(`LBP_RAMP_STEPS) << tmr.shift;

    // Step counting
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            cnt_reg  <= '0;
            run_reg  <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (tmr.start)
        begin
            // Zero-length interval ends on the next edge
            cnt_reg  <= '0;
            run_reg  <= !tmr.zero_len;
            done_reg <= tmr.zero_len;
        end
        else if (run_reg && tmr.tick)
        begin
            if (cnt_reg + 1'b1 == limit)
            begin
                run_reg  <= 1'b0;
                done_reg <= 1'b1;
            end
            else
            begin
                done_reg <= 1'b0;
            end
            cnt_reg <= cnt_reg + 1'b1;
        end
        else
        begin
            done_reg <= 1'b0;
        end
    end

    assign tmr.done = done_reg;
    // Progress scaled to 128 levels whatever the interval length
    assign tmr.frac = 7'(cnt_reg >> tmr.shift);

endmodule

`default_nettype wire

// File: core/lbp_core.sv
// Control core of a single-channel OPERATING_MODE_BIT driver: write-only register file,
// direct PWM and a breathing sequencer, repeating, or one-shot in ramp mode.
// Assumes an external serial slave delivers address and data bytes as
// one-cycle strobes on core_clk_i; the shutdown pin is asynchronous.
//
// How it works
// - Breathing peak uses duty bits 7:1 only
// - Breathing current is full scale times peak/128
// - Duty writes shadowed; zero to 0x07 applies
// - Delay field: zero, then 0.13 s doubling
// - Rise 0.13 s doubling; hold zero-able doubling
// - Fall 0.13 s doubling; off zero-able doubling
// - Timing writes shadowed; zero to 0x1c applies
// - Output driven only while output-on bit set
// - Zero to reset register restores all defaults
// - Power-up loads defaults, output starts dark
// - Mode clear gives direct 256-step PWM
// - Direct mode never changes duty itself
// - Delay once, then rise-hold-fall-off repeating
// - Ramp on, hold select zero: stay at peak
// - Ramp on, hold select one: stay off
// - Shutdown keeps every register intact
// - Software shutdown bit disables current sources
// - Low shutdown pin forces hardware shutdown
// - Mode bit 5 at 0x02, default zero
// - Ramp bit 5, hold select bit 4
// - Channel enable bit 5, soft shutdown bit 0
// - Write-only; pointer advances after each data byte
`include "lbp_cfg.svh"
`default_nettype none

module lbp_core #(
    parameter int unsigned STEP_CYCLES = `LBP_STEP_CYCLES,
    parameter int          STEP_W      = 18
) (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    // Byte strobes from the serial slave
    input  wire logic       addr_valid_i,
    input  wire logic       data_valid_i,
    input  wire logic [7:0] byte_i,
    // Pin
    input  wire logic       shutdown_pin_n_i,
    // Current source control
    output logic            led_pwm_o,
    output logic            current_enable_o,
    output logic [2:0]      current_select_o
);
    import lbp_pkg::*;

    // Refuse a step period the divider cannot count
    initial
        if (STEP_CYCLES < 1 || STEP_CYCLES >= (1 << STEP_W))
            $error("lbp_core: STEP_CYCLES out of range for STEP_W");

    // Register file, visible copies
    logic [7:0]  ptr_reg;          // Internal register pointer
    logic [7:0]  shutdown_reg;     // Enable and soft shutdown
    logic [7:0]  breath_reg;       // Ramp enable and hold select
    logic [7:0]  mode_reg;         // Operating mode
    logic [7:0]  current_reg;      // Full-scale current select
    logic [7:0]  duty_shadow_reg;  // Duty as written
    logic [7:0]  duty_reg;         // Duty in use
    logic [7:0]  delay_shadow_reg; // Timing as written
    logic [7:0]  rh_shadow_reg;
    logic [7:0]  fo_shadow_reg;
    logic [7:0]  delay_reg;        // Timing in use
    logic [7:0]  rh_reg;
    logic [7:0]  fo_reg;
    logic [7:0]  outctl_reg;       // Output on bit

    // Pin synchroniser
    logic        sd_meta_reg;      // First stage, read only by second
    logic        sd_sync_reg;      // Pin level, low means shutdown

    // Timing and sequencer
    logic [STEP_W-1:0] step_cnt_reg; // Ramp step divider
    logic        step_en_reg;      // One-cycle ramp step enable
    lbp_state_t  state_reg;        // Breathing phase
    lbp_state_t  state_next;
    logic        mode_d_reg;       // Mode bit last cycle
    logic        start_reg;        // Timer restart pulse
    logic [6:0]  level_reg;        // Breathing intensity, 0..127
    logic [6:0]  level_next;
    logic [13:0] ramp_prod;        // Peak times progress

    // PWM
    logic [7:0]  pwm_cnt_reg;      // Free-running PWM counter
    logic [7:0]  duty_eff;         // Duty compared this cycle
    logic        wr_hit;           // A data byte lands this cycle
    logic        soft_reset;       // Reset register command
    logic        sd_any;           // Any shutdown in force

    lbp_tmr_if tmr ();

    lbp_interval_timer #(
        .CNT_W (17)
    ) u_timer (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .tmr        (tmr)
    );

    assign wr_hit     = data_valid_i && !addr_valid_i;  // Address strobe wins
    assign soft_reset = wr_hit && ptr_reg == `LBP_A_RESET
                        && byte_i == `LBP_STROBE_CODE;
    assign sd_any     = shutdown_reg[`LBP_SSD_BIT] || !sd_sync_reg;

    // Register pointer: loaded by address byte, steps after each data byte
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
            ptr_reg <= 8'h00;
        else if (addr_valid_i)
            ptr_reg <= byte_i;
        else if (wr_hit)
            ptr_reg <= ptr_reg + 8'h01;
    end

    // Plain registers, write-only; writes land in shutdown, which clears nothing
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i || soft_reset)
        begin
            shutdown_reg     <= `LBP_RST_SHUTDOWN;
            breath_reg       <= `LBP_RST_ZERO;
            mode_reg         <= `LBP_RST_ZERO;
            current_reg      <= `LBP_RST_ZERO;
            duty_shadow_reg  <= `LBP_RST_ZERO;
            delay_shadow_reg <= `LBP_RST_ZERO;
            rh_shadow_reg    <= `LBP_RST_ZERO;
            fo_shadow_reg    <= `LBP_RST_ZERO;
            outctl_reg       <= `LBP_RST_OUTCTL;
        end
        else if (wr_hit)
            unique case (ptr_reg)
                `LBP_A_SHUTDOWN: shutdown_reg     <= byte_i;
                `LBP_A_BREATH:   breath_reg       <= byte_i;
                `LBP_A_MODE:     mode_reg         <= byte_i;
                `LBP_A_CURRENT:  current_reg      <= byte_i;
                `LBP_A_DUTY:     duty_shadow_reg  <= byte_i;
                `LBP_A_DELAY:    delay_shadow_reg <= byte_i;
                `LBP_A_RISEHOLD: rh_shadow_reg    <= byte_i;
                `LBP_A_FALLOFF:  fo_shadow_reg    <= byte_i;
                `LBP_A_OUTCTL:   outctl_reg       <= byte_i;
                default:         ;  // Strobes and holes store nothing
            endcase
    end

    // Active copies: only the update strobes and resets move them; timing goes as a set
    // so delay, rise-hold and fall-off change in the same cycle, even mid-sequence
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i || soft_reset)
        begin
            duty_reg  <= `LBP_RST_ZERO;
            delay_reg <= `LBP_RST_ZERO;
            rh_reg    <= `LBP_RST_ZERO;
            fo_reg    <= `LBP_RST_ZERO;
        end
        else if (wr_hit && ptr_reg == `LBP_A_DUTY_UPD && byte_i == `LBP_STROBE_CODE)
            duty_reg <= duty_shadow_reg;
        else if (wr_hit && ptr_reg == `LBP_A_TIME_UPD && byte_i == `LBP_STROBE_CODE)
        begin
            delay_reg <= delay_shadow_reg;
            rh_reg    <= rh_shadow_reg;
            fo_reg    <= fo_shadow_reg;
        end
    end

    // Two-stage synchroniser for the shutdown pin
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            sd_meta_reg <= 1'b1;
            sd_sync_reg <= 1'b1;
        end
        else
        begin
            sd_meta_reg <= shutdown_pin_n_i;
            sd_sync_reg <= sd_meta_reg;
        end
    end

    // Ramp step divider: 128 steps per shortest interval
    always_ff @(posedge core_clk_i)
    begin
        step_en_reg <= rst_b_i && step_cnt_reg == STEP_W'(STEP_CYCLES - 1);
        if (!rst_b_i || step_cnt_reg == STEP_W'(STEP_CYCLES - 1))
            step_cnt_reg <= '0;
        else
            step_cnt_reg <= step_cnt_reg + 1'b1;
    end

    // Interval length of the phase being entered
    always_comb
    begin
        tmr.zero_len = 1'b0;
        tmr.shift    = 4'h0;
        unique case (state_reg)
            LBP_DELAY:
            begin
                tmr.zero_len = delay_reg[`LBP_HI_NIB_HI:`LBP_HI_NIB_LO] == 4'h0;
                tmr.shift    = (delay_reg[`LBP_HI_NIB_HI:`LBP_HI_NIB_LO] > `LBP_DELAY_MAX)
                               ? `LBP_DELAY_MAX - 4'h1
                               : delay_reg[`LBP_HI_NIB_HI:`LBP_HI_NIB_LO] - 4'h1;
            end
            LBP_RISE: tmr.shift = {1'b0, rh_reg[`LBP_HI3_HI:`LBP_HI3_LO]};
            LBP_HOLD:
            begin
                tmr.zero_len = rh_reg[`LBP_MID4_HI:`LBP_MID4_LO] == 4'h0;
                tmr.shift    = (rh_reg[`LBP_MID4_HI:`LBP_MID4_LO] > `LBP_HOLD_MAX)
                               ? `LBP_HOLD_MAX - 4'h1
                               : rh_reg[`LBP_MID4_HI:`LBP_MID4_LO] - 4'h1;
            end
            LBP_FALL: tmr.shift = {1'b0, fo_reg[`LBP_HI3_HI:`LBP_HI3_LO]};
            LBP_OFF:
            begin
                tmr.zero_len = fo_reg[`LBP_MID4_HI:`LBP_MID4_LO] == 4'h0;
                tmr.shift    = (fo_reg[`LBP_MID4_HI:`LBP_MID4_LO] > `LBP_OFF_MAX)
                               ? `LBP_OFF_MAX - 4'h1
                               : fo_reg[`LBP_MID4_HI:`LBP_MID4_LO] - 4'h1;
            end
            LBP_IDLE: tmr.zero_len = 1'b1;
        endcase
    end

    // Timer frozen in shutdown so the sequence resumes where it stopped
    assign tmr.tick  = step_en_reg && !sd_any;
    assign tmr.start = start_reg;

    // Next phase
    always_comb
    begin
        state_next = state_reg;
        if (!mode_reg[`LBP_MODE_BIT])
            state_next = LBP_IDLE;
        else if (!mode_d_reg)
            state_next = LBP_DELAY;
        else if (tmr.done)
        begin
            unique case (state_reg)
                LBP_DELAY: state_next = LBP_RISE;
                LBP_RISE:  state_next = LBP_HOLD;
                // Ramp mode parks at peak when hold select is zero
                LBP_HOLD:
                    if (!(breath_reg[`LBP_RAMP_BIT]
                          && !breath_reg[`LBP_HOLDSEL_BIT]))
                        state_next = LBP_FALL;
                LBP_FALL:  state_next = LBP_OFF;
                // Ramp mode parks dark after one cycle when hold select is one
                LBP_OFF:
                    if (!(breath_reg[`LBP_RAMP_BIT]
                          && breath_reg[`LBP_HOLDSEL_BIT]))
                        state_next = LBP_RISE;
                LBP_IDLE:  state_next = LBP_IDLE;
            endcase
        end
    end

    // Phase, intensity and timer restart on every phase entry
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            state_reg  <= LBP_IDLE;
            mode_d_reg <= 1'b0;
            start_reg  <= 1'b0;
            level_reg  <= 7'h00;
        end
        else
        begin
            state_reg  <= state_next;
            mode_d_reg <= mode_reg[`LBP_MODE_BIT];
            start_reg  <= state_next != state_reg
                          || (tmr.done && state_next == LBP_RISE);
            level_reg  <= level_next;
        end
    end

    // Peak uses duty bits 7:1, scaled by progress through the ramp
    assign ramp_prod = duty_reg[`LBP_DUTY_HI:`LBP_DUTY_LO]
                       * ((state_reg == LBP_FALL) ? 7'h7f - tmr.frac : tmr.frac);

    // Breathing intensity
    always_comb
    begin
        level_next = 7'h00;
        unique case (state_reg)
            LBP_RISE: level_next = ramp_prod[13:7];
            LBP_HOLD: level_next = duty_reg[`LBP_DUTY_HI:`LBP_DUTY_LO];
            LBP_FALL: level_next = ramp_prod[13:7];
            LBP_IDLE, LBP_DELAY, LBP_OFF: level_next = 7'h00;
        endcase
    end

    // Level/128 equals twice the level over 256 steps
    assign duty_eff = mode_reg[`LBP_MODE_BIT] ? {level_reg, 1'b0}
                                             : duty_reg;

    // Free-running PWM counter
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
            pwm_cnt_reg <= 8'h00;
        else
            pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
    end

    // Outputs, all registered; dark unless enabled, on and not shut down
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            led_pwm_o        <= 1'b0;
            current_enable_o <= 1'b0;
            current_select_o <= 3'h0;
        end
        else
        begin
            led_pwm_o        <= pwm_cnt_reg < duty_eff
                                && outctl_reg[`LBP_OUTON_BIT]
                                && shutdown_reg[`LBP_EN_BIT] && !sd_any;
            current_enable_o <= shutdown_reg[`LBP_EN_BIT] && !sd_any;
            current_select_o <= current_reg[`LBP_CS_HI:`LBP_CS_LO];
        end
    end

endmodule

`default_nettype wire

// File: testbench/lbp_host_model.sv
// Host side of the register port: byte strobes as a serial slave gives them.
// Assumes the core samples strobes on rising edges of core_clk_i.
`include "lbp_cfg.svh"
`default_nettype none

module lbp_host_model (
    // Clock
    input  wire logic core_clk_i,
    // Byte strobes
    output logic       addr_valid_o,
    output logic       data_valid_o,
    output logic [7:0] byte_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet bus at time zero
    initial
    begin
        addr_valid_o = 1'b0;
        data_valid_o = 1'b0;
        byte_o = 8'h5a;
    end

    // One strobe, launched at the falling edge
    task automatic strobe(input logic is_addr, input logic [7:0] b);
        @(negedge core_clk_i);
        addr_valid_o = is_addr;
        data_valid_o = !is_addr;
        byte_o = b;
    endtask

    // Release; stale byte inverted so it never looks valid
    task automatic idle();
        @(negedge core_clk_i);
        addr_valid_o = 1'b0;
        data_valid_o = 1'b0;
        byte_o = ~byte_o;
    endtask

    // Single register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        strobe(1'b1, a);
        strobe(1'b0, d);
        idle();
    endtask

    // Zero to an update or reset register
    task automatic fire(input logic [7:0] a);
        wr(a, `LBP_STROBE_CODE);
    endtask
endmodule

`default_nettype wire

// File: testbench/lbp_core_properties.sv
// Port-level checker for the OPERATING_MODE_BIT driver core.
// Assumes the first data byte is always preceded by an address byte.
`include "lbp_cfg.svh"
`default_nettype none

module lbp_core_properties (
    // Clock and reset
    input wire logic       core_clk_i,
    input wire logic       rst_b_i,
    // Register strobes and pin
    input wire logic       addr_valid_i,
    input wire logic       data_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic       shutdown_pin_n_i,
    // Outputs under watch
    input wire logic       led_pwm_o,
    input wire logic       current_enable_o,
    input wire logic [2:0] current_select_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] ptr_reg;  // Mirror of the write pointer
    logic [1:0] up_reg;   // Edges with pin high, saturating
    logic       wr;       // Data byte taken this edge
    logic [2:0] cs_field; // Current field of the byte

    assign wr = data_valid_i && !addr_valid_i;
    assign cs_field = byte_i[`LBP_CS_HI:`LBP_CS_LO];

    // Pointer mirror; address strobe wins
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
            ptr_reg <= 8'h00;
        else if (addr_valid_i)
            ptr_reg <= byte_i;
        else if (data_valid_i)
            ptr_reg <= ptr_reg + 8'h01;
    end

    // Pin synchroniser must be flushed before enable can show
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i || !shutdown_pin_n_i)
            up_reg <= 2'h0;
        else if (up_reg != 2'h3)
            up_reg <= up_reg + 2'h1;
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    reset_dark_a: assert property (disable iff (1'b0) !rst_b_i |=>
        !led_pwm_o && !current_enable_o && current_select_o == 3'h0)
        else $error("outputs not dark after reset");
    pin_off_a: assert property (!shutdown_pin_n_i [*3] |=> !current_enable_o && !led_pwm_o)
        else $error("output on with shutdown pin low");
    pwm_gated_a: assert property (led_pwm_o |-> current_enable_o)
        else $error("pwm high while current disabled");
    cs_write_a: assert property (wr && ptr_reg == `LBP_A_CURRENT |->
        ##2 current_select_o == $past(cs_field, 2))
        else $error("current select not updated");
    soft_reset_a: assert property (wr && ptr_reg == `LBP_A_RESET && byte_i == 8'h00 |->
        ##2 !current_enable_o && current_select_o == 3'h0)
        else $error("soft reset left state behind");
    enable_on_a: assert property (wr && ptr_reg == `LBP_A_SHUTDOWN && byte_i[5] &&
        !byte_i[0] && up_reg == 2'h3 && shutdown_pin_n_i |-> ##2 current_enable_o)
        else $error("enable write did not enable");
    ssd_off_a: assert property (wr && ptr_reg == `LBP_A_SHUTDOWN && byte_i[0] |->
        ##2 !current_enable_o && !led_pwm_o)
        else $error("soft shutdown did not stop output");
    out_off_a: assert property (wr && ptr_reg == `LBP_A_OUTCTL && !byte_i[0] |-> ##2 !led_pwm_o)
        else $error("output off bit ignored");

    // Main scenarios reached
    soft_reset_c: cover property (wr && ptr_reg == `LBP_A_RESET && byte_i == 8'h00);
    pwm_rise_c: cover property ($rose(led_pwm_o));
    pin_low_c: cover property (!shutdown_pin_n_i [*3]);
endmodule

bind lbp_core lbp_core_properties u_props (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_valid_i(addr_valid_i),
    .data_valid_i(data_valid_i), .byte_i(byte_i), .shutdown_pin_n_i(shutdown_pin_n_i),
    .led_pwm_o(led_pwm_o), .current_enable_o(current_enable_o),
    .current_select_o(current_select_o)
);

`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the OPERATING_MODE_BIT driver core: direct and breathing modes.
// Assumes a short ramp step so breathing intervals last hundreds of cycles.
`include "lbp_cfg.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned STEP = 2;  // Rise code 0 lasts 256 cycles
    logic       core_clk_i = 1'b0;     // 250 MHz clock
    logic       rst_b_i = 1'b0;        // Active-low reset
    logic       shutdown_pin_n = 1'b1; // Pin drive
    logic       addr_valid;            // Strobes from host
    logic       data_valid;
    logic [7:0] byte_b;
    logic       led_pwm;               // Observed outputs
    logic       cur_en;
    logic [2:0] cur_sel;
    logic [7:0] duty;                  // Last applied duty
    logic [7:0] corner [3] = '{8'h00, 8'hff, 8'h04};
    int         bad_count = 0;
    int         cmp_count = 0;
    int         seed = 32'h0fd6e213;

    always #2 core_clk_i = ~core_clk_i;

    lbp_host_model host (.core_clk_i(core_clk_i), .addr_valid_o(addr_valid),
        .data_valid_o(data_valid), .byte_o(byte_b));

    lbp_core #(.STEP_CYCLES(STEP)) uut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .addr_valid_i(addr_valid), .data_valid_i(data_valid), .byte_i(byte_b),
        .shutdown_pin_n_i(shutdown_pin_n), .led_pwm_o(led_pwm),
        .current_enable_o(cur_en), .current_select_o(cur_sel));

    // High cycles in a 256-cycle window; breathing drops bit 0
    function automatic logic [15:0] exp_hi(input logic [7:0] d, input logic br);
        exp_hi = br ? {8'h00, d[7:1], 1'b0} : {8'h00, d};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Let the last write land, then count one PWM period
    task automatic expect_hi(input logic [15:0] e);
        logic [15:0] h;
        h = 16'h0000;
        repeat (3) @(posedge core_clk_i);
        repeat (256)
        begin
            @(posedge core_clk_i);
            #1;
            h += 16'(led_pwm);  // An unknown level poisons the count
        end
        check(h, e);
    endtask

    task automatic final_report();
        if (bad_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog well beyond the expected 6.5k cycles
    initial
    begin
        #200000;
        bad_count++;
        final_report();
    end

    initial
    begin
        repeat (3) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        @(posedge core_clk_i);
        #1;
        check({11'h0, led_pwm, cur_en, cur_sel}, 16'h0000);
        // Burst through the auto-incrementing pointer
        host.strobe(1'b1, `LBP_A_SHUTDOWN);
        host.strobe(1'b0, 8'h20);
        host.strobe(1'b0, 8'h00);
        host.strobe(1'b0, 8'h00);
        host.strobe(1'b0, 8'h0c);
        host.strobe(1'b0, 8'h80);
        host.idle();
        expect_hi(16'h0000);
        check({12'h0, cur_en, cur_sel}, 16'h000b);
        host.wr(`LBP_A_DUTY_UPD, 8'h5a);
        expect_hi(16'h0000);
        host.fire(`LBP_A_DUTY_UPD);
        expect_hi(16'h0080);
        // Corner then random duties
        for (int i = 0; i < 6; i++)
        begin
            duty = (i < 3) ? corner[i] : 8'($random(seed));
            host.wr(`LBP_A_DUTY, duty);
            host.fire(`LBP_A_DUTY_UPD);
            expect_hi(exp_hi(duty, 1'b0));
        end
        host.wr(`LBP_A_OUTCTL, 8'h00);
        expect_hi(16'h0000);
        host.wr(`LBP_A_OUTCTL, 8'h01);
        expect_hi(exp_hi(duty, 1'b0));
        host.wr(`LBP_A_SHUTDOWN, 8'h21);
        expect_hi(16'h0000);
        duty = 8'h33;
        host.wr(`LBP_A_DUTY, duty);
        host.fire(`LBP_A_DUTY_UPD);
        shutdown_pin_n = 1'b0;
        host.wr(`LBP_A_SHUTDOWN, 8'h20);
        expect_hi(16'h0000);
        @(negedge core_clk_i);
        shutdown_pin_n = 1'b1;
        expect_hi(exp_hi(duty, 1'b0));
        host.wr(`LBP_A_SHUTDOWN, 8'h20);
        // Breathing: delay shadow left unapplied, park at peak
        duty = 8'hff;
        host.wr(`LBP_A_DUTY, duty);
        host.fire(`LBP_A_DUTY_UPD);
        host.wr(`LBP_A_RISEHOLD, 8'h02);
        host.fire(`LBP_A_TIME_UPD);
        host.wr(`LBP_A_DELAY, 8'ha0);
        host.wr(`LBP_A_BREATH, 8'h20);
        host.wr(`LBP_A_MODE, 8'h20);
        repeat (1000) @(posedge core_clk_i);
        expect_hi(exp_hi(duty, 1'b1));
        // Restart with hold select one: one cycle, then dark
        host.wr(`LBP_A_MODE, 8'h00);
        host.wr(`LBP_A_BREATH, 8'h30);
        host.wr(`LBP_A_MODE, 8'h20);
        repeat (1000) @(posedge core_clk_i);
        expect_hi(16'h0000);
        host.fire(`LBP_A_RESET);
        expect_hi(16'h0000);
        check({12'h0, cur_en, cur_sel}, 16'h0000);
        final_report();
    end
endmodule

`default_nettype wire
